// *** rtl/pfbo_consts.svh ***
`ifndef PFBO_CONSTS_SVH
`define PFBO_CONSTS_SVH

// clock period of mclk_i in picoseconds (40 MHz)
`define PFBO_CLK_PS 25000
// pin timing figures in nanoseconds; plain defaults, tune per part
`define PFBO_ACC_NS 70
`define PFBO_CE_NS 70
`define PFBO_WS_NS 10
`define PFBO_WP_NS 35
`define PFBO_WPH_NS 25
`define PFBO_RP_NS 500
`define PFBO_RH_NS 50
// least time to cycles: round up, never below one cycle
`define PFBO_MIN_CYC(ns) ((((ns) * 1000 + `PFBO_CLK_PS - 1) / `PFBO_CLK_PS) < 1 ? 1 : \
  (((ns) * 1000 + `PFBO_CLK_PS - 1) / `PFBO_CLK_PS))
`define PFBO_ACC_CYC `PFBO_MIN_CYC(`PFBO_ACC_NS)
`define PFBO_CE_CYC `PFBO_MIN_CYC(`PFBO_CE_NS)
`define PFBO_WS_CYC `PFBO_MIN_CYC(`PFBO_WS_NS)
`define PFBO_WP_CYC `PFBO_MIN_CYC(`PFBO_WP_NS)
`define PFBO_WPH_CYC `PFBO_MIN_CYC(`PFBO_WPH_NS)
`define PFBO_RP_CYC `PFBO_MIN_CYC(`PFBO_RP_NS)
`define PFBO_RH_CYC `PFBO_MIN_CYC(`PFBO_RH_NS)
// synchroniser depth on pin inputs
`define PFBO_SYNC_CYC 2
// data pin drive masks
`define PFBO_MASK_WORD 16'hffff
`define PFBO_MASK_BYTE_WR 16'h80ff
`define PFBO_MASK_BYTE_RD 16'h8000
`define PFBO_MASK_NONE 16'h0000

`endif

// *** rtl/pfbo_host.sv ***
`timescale 1ns/100ps
`include "pfbo_consts.svh"
module pfbo_host
#(
  parameter int ACC_CYC = `PFBO_ACC_CYC, // address access cycles
  parameter int CE_CYC = `PFBO_CE_CYC, // chip select access cycles
  parameter int WS_CYC = `PFBO_WS_CYC, // write setup cycles
  parameter int WP_CYC = `PFBO_WP_CYC, // write pulse low cycles
  parameter int WPH_CYC = `PFBO_WPH_CYC, // write recovery cycles
  parameter int RP_CYC = `PFBO_RP_CYC, // clear pulse cycles
  parameter int RH_CYC = `PFBO_RH_CYC // clear recovery cycles
)
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // user request port
  input wire logic req_i,
  input wire logic [1:0] op_i,
  input wire logic [20:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic byte_mode_i,
  // user answer port
  output logic done_o,
  output logic busy_o,
  output logic [15:0] rdata_o,
  output logic aborted_o,
  // flash control pins
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic clear_n_o,
  output logic width_sel_o,
  output logic [19:0] addr_o,
  input wire logic ready_busy_out_i,
  // flash data pins
  input wire logic [15:0] data_io_bus_i,
  output logic [15:0] data_io_bus_o,
  output logic [15:0] data_io_bus_oe_o
);

  pfbo_tmr_if tmr_bus(); // phase timer link
  pfbo_pkg::pfbo_state_t state; // sequencer state
  pfbo_pkg::pfbo_op_t op; // op under way
  logic byte_mode; // latched width choice
  logic rb_meta; // ready/busy first stage
  logic rb_sync; // ready/busy synchronised
  logic [15:0] dq_meta; // data first stage
  logic [15:0] dq_sync; // data synchronised
  logic was_busy; // device busy when clear began

  // drive mask: byte mode always drives DQ15 as A-1
  function automatic logic [15:0] pfbo_oe_mask(input logic bmode, input logic wr);
    if (bmode)
      pfbo_oe_mask = wr ? `PFBO_MASK_BYTE_WR : `PFBO_MASK_BYTE_RD;
    else
      pfbo_oe_mask = wr ? `PFBO_MASK_WORD : `PFBO_MASK_NONE;
  endfunction

  // phase count with a cap so a wide parameter cannot wrap the timer
  function automatic logic [7:0] pfbo_cyc(input int n);
    pfbo_cyc = (n > 255) ? 8'hff : n[7:0];
  endfunction

  pfbo_timer u_timer
  (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .tmr(tmr_bus.tmr)
  );

  // pin inputs: two flops, only the second is read
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      rb_meta <= 1'b1;
      rb_sync <= 1'b1;
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end
    else
    begin
      rb_meta <= ready_busy_out_i;
      rb_sync <= rb_meta;
      dq_meta <= data_io_bus_i;
      dq_sync <= dq_meta;
    end
  end

  // timer load strobe and count, combinational from the sequencer
  always_comb
  begin
    tmr_bus.load = 1'b0;
    tmr_bus.count = 8'h01;
    case (state)
      pfbo_pkg::PFBO_ST_IDLE:
        if (req_i)
        begin
          tmr_bus.load = 1'b1;
          if (op_i == pfbo_pkg::PFBO_OP_READ)
            // pins come out of standby, so the slower of the two access figures counts
            tmr_bus.count = pfbo_cyc(((CE_CYC > ACC_CYC) ? CE_CYC : ACC_CYC) + `PFBO_SYNC_CYC);
          else if (op_i == pfbo_pkg::PFBO_OP_WRITE)
            tmr_bus.count = pfbo_cyc(WS_CYC);
          else
            tmr_bus.count = pfbo_cyc(RP_CYC);
        end
      pfbo_pkg::PFBO_ST_WR_SETUP:
      begin
        tmr_bus.load = tmr_bus.expired;
        tmr_bus.count = pfbo_cyc(WP_CYC);
      end
      pfbo_pkg::PFBO_ST_WR_PULSE:
      begin
        tmr_bus.load = tmr_bus.expired;
        tmr_bus.count = pfbo_cyc(WPH_CYC);
      end
      pfbo_pkg::PFBO_ST_CLR_PULSE:
      begin
        // recovery covers the synchroniser so a stale ready is not seen
        tmr_bus.load = tmr_bus.expired;
        tmr_bus.count = pfbo_cyc(RH_CYC + `PFBO_SYNC_CYC);
      end
      default:
      begin
        tmr_bus.load = 1'b0;
        tmr_bus.count = 8'h01;
      end
    endcase
  end

  // sequencer and pin drive
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state <= pfbo_pkg::PFBO_ST_IDLE;
      op <= pfbo_pkg::PFBO_OP_READ;
      byte_mode <= 1'b0;
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      we_n_o <= 1'b1;
      clear_n_o <= 1'b1;
      width_sel_o <= 1'b1;
      addr_o <= 20'h00000;
      data_io_bus_o <= 16'h0000;
      data_io_bus_oe_o <= 16'h0000;
      rdata_o <= 16'h0000;
      done_o <= 1'b0;
      busy_o <= 1'b0;
      aborted_o <= 1'b0;
      was_busy <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state)
        pfbo_pkg::PFBO_ST_IDLE:
          // idle keeps select and clear high: the device sits in standby
          if (req_i)
          begin
            // the spare code acts as a clear, so it is kept as one for the checks below
            op <= op_i[1] ? pfbo_pkg::PFBO_OP_CLEAR : pfbo_pkg::pfbo_op_t'(op_i);
            byte_mode <= byte_mode_i;
            width_sel_o <= ~byte_mode_i;
            addr_o <= addr_i[20:1];
            data_io_bus_o <= byte_mode_i ? {addr_i[0], 7'h00, wdata_i[7:0]} : wdata_i;
            busy_o <= 1'b1;
            aborted_o <= 1'b0;
            if (op_i == pfbo_pkg::PFBO_OP_READ)
            begin
              ce_n_o <= 1'b0;
              oe_n_o <= 1'b0;
              data_io_bus_oe_o <= pfbo_oe_mask(byte_mode_i, 1'b0);
              state <= pfbo_pkg::PFBO_ST_RD_ACC;
            end
            else if (op_i == pfbo_pkg::PFBO_OP_WRITE)
            begin
              // every command word, including short-program pairs, is one such cycle
              ce_n_o <= 1'b0;
              data_io_bus_oe_o <= pfbo_oe_mask(byte_mode_i, 1'b1);
              state <= pfbo_pkg::PFBO_ST_WR_SETUP;
            end
            else
            begin
              // select already high; it stays high across the pulse
              clear_n_o <= 1'b0;
              was_busy <= ~rb_sync;
              state <= pfbo_pkg::PFBO_ST_CLR_PULSE;
            end
          end
        pfbo_pkg::PFBO_ST_RD_ACC:
          if (tmr_bus.expired)
          begin
            // status and identification data live in the low byte only
            rdata_o <= byte_mode ? {8'h00, dq_sync[7:0]} : dq_sync;
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            data_io_bus_oe_o <= 16'h0000;
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state <= pfbo_pkg::PFBO_ST_IDLE;
          end
        pfbo_pkg::PFBO_ST_WR_SETUP:
          if (tmr_bus.expired)
          begin
            we_n_o <= 1'b0;
            state <= pfbo_pkg::PFBO_ST_WR_PULSE;
          end
        pfbo_pkg::PFBO_ST_WR_PULSE:
          if (tmr_bus.expired)
          begin
            we_n_o <= 1'b1;
            state <= pfbo_pkg::PFBO_ST_WR_RECOV;
          end
        pfbo_pkg::PFBO_ST_WR_RECOV:
          if (tmr_bus.expired)
          begin
            // deselect is safe mid-algorithm: the device carries on alone
            ce_n_o <= 1'b1;
            data_io_bus_oe_o <= 16'h0000;
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state <= pfbo_pkg::PFBO_ST_IDLE;
          end
        pfbo_pkg::PFBO_ST_CLR_PULSE:
          if (tmr_bus.expired)
          begin
            clear_n_o <= 1'b1;
            state <= pfbo_pkg::PFBO_ST_CLR_RECOV;
          end
        pfbo_pkg::PFBO_ST_CLR_RECOV:
          if (tmr_bus.expired)
            state <= pfbo_pkg::PFBO_ST_CLR_WAIT;
        pfbo_pkg::PFBO_ST_CLR_WAIT:
          // no timeout: a device that never reports ready hangs here
          if (rb_sync)
          begin
            // device now reads array data; software must redo the lost op
            aborted_o <= was_busy;
            done_o <= 1'b1;
            busy_o <= 1'b0;
            state <= pfbo_pkg::PFBO_ST_IDLE;
          end
        default:
          state <= pfbo_pkg::PFBO_ST_IDLE;
      endcase
    end
  end

  // helper counters for the checks below
  logic [15:0] clr_low_cnt; // cycles clear held low
  logic [15:0] ce_low_cnt; // cycles select held low
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      clr_low_cnt <= 16'h0000;
      ce_low_cnt <= 16'h0000;
    end
    else
    begin
      clr_low_cnt <= clear_n_o ? 16'h0000 : clr_low_cnt + 16'h0001;
      ce_low_cnt <= ce_n_o ? 16'h0000 : ce_low_cnt + 16'h0001;
    end
  end

  localparam int RB_SETTLE = 8; // cycles allowed for the write strobe to rise again in word writes

  sequence s_clear_released;
    $rose(clear_n_o);
  endsequence

  sequence s_read_done;
    done_o && (op == pfbo_pkg::PFBO_OP_READ);
  endsequence

  chk_read_levels: assert property (@(posedge mclk_i) disable iff (reset_i)
    !oe_n_o |-> (we_n_o && !ce_n_o))
    else $error("output gate low without select low and write high");

  chk_write_levels: assert property (@(posedge mclk_i) disable iff (reset_i)
    !we_n_o |-> (oe_n_o && !ce_n_o && clear_n_o))
    else $error("write strobe low with gate low or select high");

  chk_select_after_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_clear_released |-> ce_n_o[*2])
    else $error("select fell too soon after clear release");

  chk_clear_width: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_clear_released |-> ($past(clr_low_cnt) >= 16'(RP_CYC)))
    else $error("clear pulse shorter than minimum width");

  chk_read_access: assert property (@(posedge mclk_i) disable iff (reset_i)
    s_read_done |-> ($past(ce_low_cnt) >= 16'(CE_CYC + `PFBO_SYNC_CYC)))
    else $error("read data taken before select access time");

  chk_byte_float: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!width_sel_o && !ce_n_o) |-> (data_io_bus_oe_o[14:8] == 7'h00 && data_io_bus_oe_o[15]))
    else $error("byte mode drives upper pins or drops A-1");

  chk_no_contention: assert property (@(posedge mclk_i) disable iff (reset_i)
    !oe_n_o |-> (data_io_bus_oe_o[7:0] == 8'h00))
    else $error("host drives data while device may drive");

  chk_standby_idle: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state == pfbo_pkg::PFBO_ST_IDLE && !done_o) |-> (ce_n_o && clear_n_o && oe_n_o && we_n_o))
    else $error("idle without standby pin levels");

  chk_clear_ready: assert property (@(posedge mclk_i) disable iff (reset_i)
    (done_o && op == pfbo_pkg::PFBO_OP_CLEAR) |-> $past(rb_sync))
    else $error("clear finished while device reported busy");

  chk_ready_finishes: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state == pfbo_pkg::PFBO_ST_CLR_WAIT && rb_sync) |-> ##1 (done_o ##1 !busy_o[*1]))
    else $error("ready seen but clear did not finish");

  chk_word_mode: assert property (@(posedge mclk_i) disable iff (reset_i)
    (width_sel_o && !we_n_o) |-> (data_io_bus_oe_o == 16'hffff) ##[1:RB_SETTLE] we_n_o)
    else $error("word write not driving all pins");

endmodule

// *** rtl/pfbo_pkg.sv ***
package pfbo_pkg;

  // operations that the user port may request
  typedef enum logic [1:0] {
    PFBO_OP_READ = 2'h0,
    PFBO_OP_WRITE = 2'h1,
    PFBO_OP_CLEAR = 2'h2
  } pfbo_op_t;

  // pin sequencer states, one-hot
  typedef enum logic [7:0] {
    PFBO_ST_IDLE = 8'h01,
    PFBO_ST_RD_ACC = 8'h02,
    PFBO_ST_WR_SETUP = 8'h04,
    PFBO_ST_WR_PULSE = 8'h08,
    PFBO_ST_WR_RECOV = 8'h10,
    PFBO_ST_CLR_PULSE = 8'h20,
    PFBO_ST_CLR_RECOV = 8'h40,
    PFBO_ST_CLR_WAIT = 8'h80
  } pfbo_state_t;

endpackage

// *** rtl/pfbo_timer.sv ***
`timescale 1ns/100ps
module pfbo_timer
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // control
  pfbo_tmr_if.tmr tmr
);

  logic [7:0] cnt; // cycles left

  // load wins over counting so a back-to-back phase starts clean
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      cnt <= 8'h00;
    else if (tmr.load)
      cnt <= tmr.count;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
  end

  assign tmr.expired = (cnt == 8'h00);

endmodule

// *** rtl/pfbo_tmr_if.sv ***
`timescale 1ns/100ps
// carries a load request and the expiry flag between sequencer and timer
interface pfbo_tmr_if;
  logic load; // one-cycle load strobe
  logic [7:0] count; // cycles to run
  logic expired; // counter reached zero
  modport ctrl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface

// *** tb/pfbo_flash_model.sv ***
`timescale 1ns/100ps
// behavioural device: small array, unlock decoder, timed program and sector erase, clear pin
module pfbo_flash_model
#(
  parameter int ACC_CYC = 3, // select to valid data, cycles
  parameter int PROG_CYC = 40, // program time, cycles
  parameter int ERASE_CYC = 60, // sector erase time, cycles
  parameter int RB_CYC = 30, // internal clear time if busy
  parameter logic [7:0] MAKER_CODE = 8'h5a // arbitrary value
)
(
  // clock for internal timing
  input wire logic mclk_i,
  // control pins
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic clear_n_i,
  input wire logic width_sel_i,
  input wire logic [19:0] addr_i,
  // data pins and status
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe_o,
  output logic ready_busy_out_o
);
  logic [15:0] mem [0:255]; // 256 words keep the model small
  logic [2:0] mode = 3'h0; // 0 array, 1-2 unlock, 3 program, 4 id, 5 bypass, 6 bypass program, 7 erase
  logic [7:0] busy_cnt = 8'h00; // program, sector erase or internal clear left
  logic [7:0] acc_cnt = 8'h00; // cycles since read select
  logic prog_live = 1'b0; // program still pending
  logic erase_live = 1'b0; // sector erase still pending
  logic [1:0] ers = 2'h0; // second unlock pair seen inside the erase string
  logic [3:0] esec = 4'h0; // sector under erase: sixteen words each
  logic we_d = 1'b1;
  logic [15:0] pdata;
  logic [7:0] paddr;
  logic [15:0] arr;
  logic [15:0] rd;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = {i[7:0], ~i[7:0]};
  end

  // commands act on the rising write strobe; a low clear pin wins over all
  always @(posedge mclk_i)
  begin
    we_d <= we_n_i;
    acc_cnt <= (ce_n_i || oe_n_i) ? 8'h00 : acc_cnt + {7'h00, acc_cnt != 8'hff};
    // logic levels only: the high-voltage unprotect entry is never seen here
    if (!clear_n_i)
    begin
      mode <= 3'h0;
      ers <= 2'h0;
      prog_live <= 1'b0;
      erase_live <= 1'b0;
      if (prog_live || erase_live)
        busy_cnt <= 8'(RB_CYC);
    end
    else
    begin
      if (busy_cnt != 8'h00)
        busy_cnt <= busy_cnt - 8'h01;
      if (busy_cnt == 8'h01 && prog_live)
      begin
        mem[paddr] <= pdata;
        prog_live <= 1'b0;
      end
      // a whole sector goes to the erased level at the end
      if (busy_cnt == 8'h01 && erase_live)
      begin
        for (int j = 0; j < 16; j++)
          mem[{esec, j[3:0]}] <= 16'hffff;
        erase_live <= 1'b0;
      end
      if (we_n_i && !we_d && !ce_n_i && busy_cnt == 8'h00)
      begin
        if (mode == 3'h3 || mode == 3'h6)
        begin
          paddr <= addr_i[7:0];
          pdata <= dq_i;
          prog_live <= 1'b1;
          busy_cnt <= 8'(PROG_CYC);
          mode <= (mode == 3'h6) ? 3'h5 : 3'h0;
        end
        else if (mode == 3'h5)
          mode <= (dq_i[7:0] == 8'ha0) ? 3'h6 : 3'h5;
        else if (mode == 3'h7 && ers == 2'h2)
        begin
          // sector code ends the erase string; anything else drops it
          mode <= 3'h0;
          ers <= 2'h0;
          if (dq_i[7:0] == 8'h30)
          begin
            esec <= addr_i[7:4];
            erase_live <= 1'b1;
            pdata <= 16'hffff;
            busy_cnt <= 8'(ERASE_CYC);
          end
        end
        else if (mode == 3'h7)
        begin
          // erase arms on 80, then wants a fresh aa, 55 pair
          if (dq_i[7:0] == ((ers == 2'h0) ? 8'haa : 8'h55))
            ers <= ers + 2'h1;
          else
          begin
            mode <= 3'h0;
            ers <= 2'h0;
          end
        end
        else if (dq_i[7:0] == 8'hf0)
          mode <= 3'h0;
        else if (mode == 3'h1)
          mode <= (dq_i[7:0] == 8'h55) ? 3'h2 : 3'h0;
        else if (mode == 3'h2)
          mode <= (dq_i[7:0] == 8'ha0) ? 3'h3 : (dq_i[7:0] == 8'h90) ? 3'h4 :
            (dq_i[7:0] == 8'h20) ? 3'h5 : (dq_i[7:0] == 8'h80) ? 3'h7 : 3'h0;
        else if (dq_i[7:0] == 8'haa)
          mode <= 3'h1;
      end
    end
  end

  // status while busy, codes in id mode, else the array
  always_comb
  begin
    arr = mem[addr_i[7:0]];
    if (!width_sel_i)
      arr = {8'h00, dq_i[15] ? arr[15:8] : arr[7:0]};
    rd = arr;
    if (busy_cnt != 8'h00)
      rd = {8'h00, ~pdata[7], acc_cnt[0] ^ busy_cnt[0], 6'h00};
    else if (mode == 3'h4)
      rd = {8'h00, MAKER_CODE};
  end

  // only a plain read drives; standby, clear and writes float the pins
  assign dq_oe_o = (!ce_n_i && !oe_n_i && we_n_i && clear_n_i) ?
    (width_sel_i ? 16'hffff : 16'h00ff) : 16'h0000;
  // garbage until the access time, then held while the address stays
  assign dq_o = (acc_cnt >= 8'(ACC_CYC)) ? rd : ~rd;
  assign ready_busy_out_o = (busy_cnt == 8'h00);
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
// host against the device model: reads, commands, programs, clears
module tb_top;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary code, shared with the model
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic [1:0] op = 2'h0;
  logic [20:0] addr = 21'h000000;
  logic [15:0] wdata = 16'h0000;
  logic bm = 1'b0;
  logic done, busy, aborted, ce_n, oe_n, we_n, clr_n, wsel, rb;
  logic [15:0] rdata, dq_h, dq_hoe, dq_m, dq_moe, dq;
  logic [19:0] apin;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [31:0] rs = 32'hdaa3387f; // fixed start keeps runs repeatable

  // a released bit follows the cycle count instead of keeping its last value
  assign dq = (dq_hoe & dq_h) | (~dq_hoe & dq_moe & dq_m) | (~dq_hoe & ~dq_moe & (cyc[15:0] ^ 16'h5a5a));

  pfbo_host uut
  (
    .mclk_i(mclk), .reset_i(rst), .req_i(req), .op_i(op), .addr_i(addr), .wdata_i(wdata),
    .byte_mode_i(bm), .done_o(done), .busy_o(busy), .rdata_o(rdata), .aborted_o(aborted),
    .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .clear_n_o(clr_n), .width_sel_o(wsel),
    .addr_o(apin), .ready_busy_out_i(rb), .data_io_bus_i(dq), .data_io_bus_o(dq_h),
    .data_io_bus_oe_o(dq_hoe)
  );

  pfbo_flash_model #(.MAKER_CODE(MAKER)) dev
  (
    .mclk_i(mclk), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .clear_n_i(clr_n),
    .width_sel_i(wsel), .addr_i(apin), .dq_i(dq), .dq_o(dq_m), .dq_oe_o(dq_moe),
    .ready_busy_out_o(rb)
  );

  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  // hang guard, far above the under one thousand cycles the run needs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // untouched array word and byte at an index
  function automatic logic [15:0] wexp(input logic [7:0] i);
    return {i, ~i};
  endfunction

  function automatic logic [15:0] bexp(input logic [8:0] a);
    return {8'h00, a[0] ? a[8:1] : ~a[8:1]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one request held a single cycle, then wait for the done pulse
  task automatic do_op(input logic [1:0] c, input logic [20:0] a, input logic [15:0] d, input logic b);
    @(negedge mclk);
    req = 1'b1;
    op = c;
    addr = a;
    wdata = d;
    bm = b;
    @(negedge mclk);
    req = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    while (done !== 1'b1)
      @(negedge mclk);
    chk({15'h0000, busy}, 16'h0000);
  endtask

  task automatic rd(input logic [20:0] a, input logic b);
    do_op(2'h0, a, 16'h0000, b);
  endtask

  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    do_op(2'h1, a, d, 1'b0);
  endtask

  task automatic unlock();
    wr(21'h000aaa, 16'h00aa);
    wr(21'h000554, 16'h0055);
  endtask

  // program, poll the status bit until done, then read back
  task automatic prog(input logic [20:0] a, input logic [15:0] d, input logic fast);
    int n;
    n = 0;
    if (!fast)
      unlock();
    wr(21'h000aaa, 16'h00a0);
    wr(a, d);
    rd(a, 1'b0);
    chk({15'h0000, rdata[7]}, {15'h0000, ~d[7]});
    while (rdata[7] !== d[7] && n < 40)
    begin
      rd(a, 1'b0);
      n++;
    end
    chk(rdata, d);
  endtask

  task automatic report_and_stop();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    // random reads straight after reset, word and then byte
    for (int i = 0; i < 6; i++)
    begin
      rs = xs(rs);
      rd({12'h000, rs[8:1], 1'b0}, 1'b0);
      chk(rdata, wexp(rs[8:1]));
      rd({12'h000, rs[8:0]}, 1'b1);
      chk(rdata, bexp(rs[8:0]));
    end
    // identification code, then back to the array
    unlock();
    wr(21'h000aaa, 16'h0090);
    rd(21'h000000, 1'b0);
    chk(rdata, {8'h00, MAKER});
    wr(21'h000000, 16'h00f0);
    rd(21'h000002, 1'b0);
    chk(rdata, wexp(8'h01));
    rs = xs(rs);
    prog(21'h000020, rs[15:0], 1'b0);
    // erase the sector holding that word; the next sector stays as it was
    unlock();
    wr(21'h000aaa, 16'h0080);
    unlock();
    wr(21'h000020, 16'h0030);
    rd(21'h000020, 1'b0);
    chk({15'h0000, rdata[7]}, 16'h0000);
    for (int k = 0; k < 40 && rdata[7] !== 1'b1; k++)
      rd(21'h000020, 1'b0);
    chk(rdata, 16'hffff);
    rd(21'h00003e, 1'b0);
    chk(rdata, 16'hffff);
    rd(21'h00005e, 1'b0);
    chk(rdata, wexp(8'h2f));
    // short program mode: two writes per word
    unlock();
    wr(21'h000aaa, 16'h0020);
    rs = xs(rs);
    prog(21'h000040, rs[15:0], 1'b1);
    // clear in the middle of a program
    wr(21'h000aaa, 16'h00a0);
    wr(21'h000060, 16'h1234);
    rd(21'h000060, 1'b0);
    do_op(2'h2, 21'h000000, 16'h0000, 1'b0);
    chk({15'h0000, aborted}, 16'h0001);
    rd(21'h000060, 1'b0);
    chk(rdata, wexp(8'h30));
    rs = xs(rs);
    prog(21'h000060, rs[15:0], 1'b0);
    // clear with nothing running, through the spare op code
    do_op(2'h3, 21'h000000, 16'h0000, 1'b0);
    chk({15'h0000, aborted}, 16'h0000);
    rd(21'h000081, 1'b1);
    chk(rdata, bexp(9'h081));
    report_and_stop();
  end
endmodule
